// ==== rtl/utc_pkg.sv ====
// constants, field layout and types shared by the upper timer/counter control block
package utc_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_CTRL  = 6'h16;  // upper_timer_control
  localparam logic [5:0] IDX_PW    = 6'h18;  // upper_pulse_width
  localparam logic [5:0] IDX_PER   = 6'h1A;  // upper_period_compare
  localparam logic [5:0] IDX_CFG   = 6'h1C;  // divider tap and power mode
  localparam logic [5:0] IDX_CNT   = 6'h1D;  // live counter value, read only
  localparam logic [5:0] IDX_IST   = 6'h1E;  // sticky event status, read only
  localparam logic [5:0] IDX_IEN   = 6'h1F;  // event enable
  localparam logic [5:0] IDX_ICLR  = 6'h20;  // write one to clear status

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CTRL  = 8'h00;
  localparam logic [7:0] RST_PW    = 8'hFF;
  localparam logic [7:0] RST_PER   = 8'hFF;
  localparam logic [7:0] RST_ZERO  = 8'h00;

  // ----------------------------------------------------------------
  // control, configuration and status field positions
  // ----------------------------------------------------------------
  localparam int CTL_FF      = 7;
  localparam int CTL_CK_HI   = 6;
  localparam int CTL_CK_LO   = 4;
  localparam int CTL_RUN     = 3;
  localparam int CTL_MODE_HI = 2;
  localparam int CTL_MODE_LO = 0;
  localparam int CFG_TAP     = 0;
  localparam int CFG_PWR_HI  = 2;
  localparam int CFG_PWR_LO  = 1;
  localparam int IST_MATCH   = 0;
  localparam int IST_BADCLK  = 1;
  localparam int IST_W       = 2;

  // ----------------------------------------------------------------
  // prescaler taps (exponents of two on the high-frequency clock)
  // ----------------------------------------------------------------
  localparam int PRE_W       = 11;
  localparam int EXP_A       = 11;
  localparam int EXP_B       = 7;
  localparam int EXP_C       = 5;
  localparam int EXP_D       = 3;
  localparam int EXP_E       = 1;
  localparam int LF_DIV_W    = 3;

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    UTC_M_TIMER8   = 3'b000,
    UTC_M_PDO8     = 3'b001,
    UTC_M_PWM8     = 3'b010,
    UTC_M_RSVD     = 3'b011,
    UTC_M_TIMER16  = 3'b100,
    UTC_M_WARMUP   = 3'b101,
    UTC_M_PWM16    = 3'b110,
    UTC_M_PPG16    = 3'b111
  } utc_mode_e;

  typedef enum logic [2:0] {
    UTC_CK_DIV11   = 3'b000,
    UTC_CK_DIV7    = 3'b001,
    UTC_CK_DIV5    = 3'b010,
    UTC_CK_DIV3    = 3'b011,
    UTC_CK_LOW     = 3'b100,
    UTC_CK_DIV1    = 3'b101,
    UTC_CK_FULL    = 3'b110,
    UTC_CK_PIN     = 3'b111
  } utc_clk_e;

endpackage

// ==== rtl/utc_upper_timer.sv ====
// upper 8-bit timer/counter unit: registers, clock select, counter and events
`timescale 1ns/1ps
`default_nettype none

module utc_upper_timer (
  // clock and reset
  input  wire  logic        mclk_in,
  input  wire  logic        rst_in,
  // wishbone classic slave
  input  wire  logic        wb_cyc_in,
  input  wire  logic        wb_stb_in,
  input  wire  logic        wb_we_in,
  input  wire  logic [7:0]  wb_adr_in,
  input  wire  logic [3:0]  wb_sel_in,
  input  wire  logic [31:0] wb_dat_in,
  output logic              wb_ack_out,
  output logic       [31:0] wb_dat_out,
  // pins and cascade
  input  wire  logic        low_freq_clk_in,
  input  wire  logic        counter_pin_in,
  input  wire  logic        cascade_ovf_in,
  input  wire  logic        lower_match_in,
  // results
  output logic              timer_ff_out,
  output logic              upper_match_irq_out,
  output logic              irq_out
);
  import utc_pkg::*;

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  logic [7:0]         upper_timer_control;
  logic [7:0]         upper_pulse_width;
  logic [7:0]         upper_period_compare;
  logic [7:0]         cfg_reg;
  logic [7:0]         counter;
  logic [IST_W-1:0]   irq_status;
  logic [IST_W-1:0]   irq_enable;
  logic [PRE_W-1:0]   prescale;
  logic [LF_DIV_W-1:0] lf_div;
  logic [2:0]         lf_sync;
  logic [2:0]         pin_sync;

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  logic      run_control;
  logic      output_flipflop_ctl;
  utc_clk_e  clock_select_field;
  utc_mode_e mode_select_field;
  logic      divider_tap_select;
  logic      slow_mode;
  logic      mode16;

  assign run_control         = upper_timer_control[CTL_RUN];
  assign output_flipflop_ctl = upper_timer_control[CTL_FF];
  assign clock_select_field  = utc_clk_e'(upper_timer_control[CTL_CK_HI:CTL_CK_LO]);
  assign mode_select_field   = utc_mode_e'(upper_timer_control[CTL_MODE_HI:CTL_MODE_LO]);
  assign divider_tap_select  = cfg_reg[CFG_TAP];
  assign slow_mode           = cfg_reg[CFG_PWR_HI];  // slow and sleep share the top bit
  assign mode16              = mode_select_field[CTL_MODE_HI];

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic       bus_req;
  logic       wr_stb;
  logic [5:0] reg_idx;
  logic [7:0] wdat;

  assign bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign wr_stb  = bus_req & wb_we_in & wb_sel_in[0];
  assign reg_idx = wb_adr_in[7:2];
  assign wdat    = wb_dat_in[7:0];

  // true when a write hits the given register index
  function automatic logic wr_hit(input logic [5:0] idx);
    wr_hit = wr_stb && (reg_idx == idx);
  endfunction

  // ----------------------------------------------------------------
  // synchronisers and clock taps
  // ----------------------------------------------------------------
  // pins come from outside the clock domain; stage 0 only feeds stage 1
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      lf_sync  <= 3'h0;
      pin_sync <= 3'h0;
    end else begin
      lf_sync  <= {lf_sync[1:0], low_freq_clk_in};
      pin_sync <= {pin_sync[1:0], counter_pin_in};
    end
  end

  logic lf_tick;
  logic pin_fall;
  assign lf_tick  = lf_sync[1] & ~lf_sync[2];
  assign pin_fall = ~pin_sync[1] & pin_sync[2];

  // free-running prescaler on the high-frequency (system) clock
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      prescale <= '0;
      lf_div   <= '0;
    end else begin
      prescale <= prescale + 1'b1;
      if (lf_tick) begin
        lf_div <= lf_div + 1'b1;
      end
    end
  end

  // one-cycle tick every 2^e system clocks
  function automatic logic tap(input int e);
    tap = &prescale[e-1 -: 1] && ((prescale & PRE_W'((1 << e) - 1)) == PRE_W'((1 << e) - 1));
  endfunction

  logic lf_div_tick;
  assign lf_div_tick = lf_tick && (&lf_div);

  // source tick per clock select, tap and power mode
  logic src_tick;
  logic bad_clk;
  always_comb begin
    src_tick = 1'b0;
    bad_clk  = 1'b0;
    if (mode16) begin
      src_tick = cascade_ovf_in;
    end else if (slow_mode) begin
      unique case (clock_select_field)
        UTC_CK_DIV11: src_tick = lf_div_tick;
        UTC_CK_LOW:   src_tick = lf_tick;
        UTC_CK_PIN:   src_tick = pin_fall;
        default:      bad_clk  = 1'b1;
      endcase
    end else begin
      unique case (clock_select_field)
        UTC_CK_DIV11: src_tick = divider_tap_select ? lf_div_tick : tap(EXP_A);
        UTC_CK_DIV7:  src_tick = tap(EXP_B);
        UTC_CK_DIV5:  src_tick = tap(EXP_C);
        UTC_CK_DIV3:  src_tick = tap(EXP_D);
        UTC_CK_LOW:   src_tick = lf_tick;
        UTC_CK_DIV1:  src_tick = tap(EXP_E);
        UTC_CK_FULL:  src_tick = 1'b1;
        UTC_CK_PIN:   src_tick = pin_fall;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers written by software
  // ----------------------------------------------------------------
  // while running only the run bit moves; a stop write keeps the fields
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      upper_timer_control <= RST_CTRL;
    end else if (wr_hit(IDX_CTRL)) begin
      if (run_control) begin
        upper_timer_control[CTL_RUN] <= wdat[CTL_RUN];
      end else begin
        upper_timer_control <= wdat;
      end
    end
  end

  // period compare frozen while running, guarding against a missed match
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      upper_period_compare <= RST_PER;
    end else if (wr_hit(IDX_PER) && !run_control) begin
      upper_period_compare <= wdat;
    end
  end

  logic pwm_mode;
  assign pwm_mode = (mode_select_field == UTC_M_PWM8) || (mode_select_field == UTC_M_PWM16);

  // pulse width takes live updates only in the PWM modes
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      upper_pulse_width <= RST_PW;
    end else if (wr_hit(IDX_PW) && (!run_control || pwm_mode)) begin
      upper_pulse_width <= wdat;
    end
  end

  // configuration and event enable
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      cfg_reg    <= RST_ZERO;
      irq_enable <= '0;
    end else begin
      if (wr_hit(IDX_CFG)) begin
        cfg_reg <= wdat;
      end
      if (wr_hit(IDX_IEN)) begin
        irq_enable <= wdat[IST_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  logic       clears_on_match;
  logic       match_evt;
  logic [7:0] next_counter;
  assign clears_on_match = !pwm_mode && (mode_select_field != UTC_M_RSVD);
  assign next_counter    = counter + 8'h01;

  // 16-bit match waits for the lower half as well
  always_comb begin
    match_evt = 1'b0;
    if (run_control && clears_on_match) begin
      if (mode16) begin
        match_evt = (counter == upper_period_compare) && lower_match_in;
      end else begin
        match_evt = src_tick && (next_counter == upper_period_compare);
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      counter <= RST_ZERO;
    end else if (!run_control || mode_select_field == UTC_M_RSVD) begin
      counter <= RST_ZERO;
    end else if (match_evt) begin
      counter <= RST_ZERO;
    end else if (src_tick) begin
      counter <= next_counter;
    end
  end

  // ----------------------------------------------------------------
  // timer flip-flop
  // ----------------------------------------------------------------
  // loaded from the control field while stopped, toggled by compares
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      timer_ff_out <= 1'b0;
    end else if (!run_control) begin
      timer_ff_out <= output_flipflop_ctl;
    end else if (mode_select_field == UTC_M_PDO8 && match_evt) begin
      timer_ff_out <= ~timer_ff_out;
    end else if ((pwm_mode || mode_select_field == UTC_M_PPG16) && src_tick
                 && (counter == upper_pulse_width)) begin
      timer_ff_out <= ~timer_ff_out;
    end
  end

  // ----------------------------------------------------------------
  // events and interrupt
  // ----------------------------------------------------------------
  logic [IST_W-1:0] evt;
  logic [IST_W-1:0] clr;
  assign evt = {run_control && bad_clk, match_evt};
  assign clr = wr_hit(IDX_ICLR) ? wdat[IST_W-1:0] : '0;

  // set beats clear in the same cycle
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      irq_status          <= '0;
      irq_out             <= 1'b0;
      upper_match_irq_out <= 1'b0;
    end else begin
      irq_status          <= (irq_status & ~clr) | evt;
      irq_out             <= |(irq_status & irq_enable);
      upper_match_irq_out <= match_evt;
    end
  end

  // ----------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------
  // one wait state, unmapped reads return zero and still ack
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= '0;
    end else begin
      wb_ack_out <= bus_req;
      wb_dat_out <= '0;
      if (bus_req && !wb_we_in) begin
        unique case (reg_idx)
          IDX_CTRL: wb_dat_out[7:0] <= upper_timer_control;
          IDX_PW:   wb_dat_out[7:0] <= upper_pulse_width;
          IDX_PER:  wb_dat_out[7:0] <= upper_period_compare;
          IDX_CFG:  wb_dat_out[7:0] <= cfg_reg;
          IDX_CNT:  wb_dat_out[7:0] <= counter;
          IDX_IST:  wb_dat_out[IST_W-1:0] <= irq_status;
          IDX_IEN:  wb_dat_out[IST_W-1:0] <= irq_enable;
          default:  wb_dat_out <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_reset_values: assert property (@(posedge mclk_in) rst_in |=>
    upper_period_compare == RST_PER && upper_pulse_width == RST_PW
    && upper_timer_control == RST_CTRL)
    else $error("register reset values wrong");

  a_period_idle_write: assert property (@(posedge mclk_in) disable iff (rst_in)
    wr_hit(IDX_PER) && !run_control |=> upper_period_compare == $past(wdat))
    else $error("period write while stopped lost");

  a_stop_keeps_fields: assert property (@(posedge mclk_in) disable iff (rst_in)
    run_control && wr_hit(IDX_CTRL) && !wdat[CTL_RUN] |=>
    !run_control && upper_timer_control[CTL_FF:CTL_CK_LO] == $past(upper_timer_control[CTL_FF:CTL_CK_LO])
    && mode_select_field == $past(mode_select_field))
    else $error("stop write altered fields");

  a_full_clock_count: assert property (@(posedge mclk_in) disable iff (rst_in)
    run_control && !mode16 && !slow_mode && clock_select_field == UTC_CK_FULL
    && mode_select_field != UTC_M_RSVD
    && (!clears_on_match || next_counter != upper_period_compare)
    |=> counter == $past(next_counter))
    else $error("undivided clock did not count");

  a_slow_clock_limit: assert property (@(posedge mclk_in) disable iff (rst_in)
    slow_mode && !mode16 && clock_select_field == UTC_CK_DIV7 |-> !src_tick)
    else $error("forbidden slow clock selected");

  a_cascade_clock: assert property (@(posedge mclk_in) disable iff (rst_in)
    run_control && mode16 && clears_on_match && !match_evt
    |=> counter == ($past(cascade_ovf_in) ? $past(next_counter) : $past(counter)))
    else $error("16-bit stage not on cascade");

  a_match_clears: assert property (@(posedge mclk_in) disable iff (rst_in)
    match_evt |=> counter == RST_ZERO && upper_match_irq_out && irq_status[IST_MATCH])
    else $error("match did not clear or flag");

  a_pin_falling: assert property (@(posedge mclk_in) disable iff (rst_in)
    run_control && !mode16 && !slow_mode && clock_select_field == UTC_CK_PIN
    && mode_select_field == UTC_M_TIMER8 && $fell(pin_sync[1])
    |-> src_tick ##1 (counter == $past(next_counter) || counter == RST_ZERO))
    else $error("pin falling edge missed");

  a_stop_zeroes: assert property (@(posedge mclk_in) disable iff (rst_in)
    $fell(run_control) |=> counter == RST_ZERO)
    else $error("counter not zero after stop");

  a_ff_load: assert property (@(posedge mclk_in) disable iff (rst_in)
    !run_control ##1 !run_control |-> timer_ff_out == $past(output_flipflop_ctl))
    else $error("flip-flop not from control field");

  a_reserved_idle: assert property (@(posedge mclk_in) disable iff (rst_in)
    mode_select_field == UTC_M_RSVD |=> counter == RST_ZERO)
    else $error("reserved mode counted");

endmodule

`default_nettype wire

// ==== test/tb_utc_upper_timer.sv ====
// self-checking bench for the upper timer/counter control block
`timescale 1ns/1ps
`default_nettype none

module tb_utc_upper_timer;
  import utc_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        mclk_in;
  logic        rst_in;
  logic        wb_cyc_in;
  logic        wb_stb_in;
  logic        wb_we_in;
  logic [7:0]  wb_adr_in;
  logic [3:0]  wb_sel_in;
  logic [31:0] wb_dat_in;
  logic        wb_ack_out;
  logic [31:0] wb_dat_out;
  logic        low_freq_clk_in;
  logic        counter_pin_in;
  logic        cascade_ovf_in;
  logic        lower_match_in;
  logic        timer_ff_out;
  logic        upper_match_irq_out;
  logic        irq_out;
  int          error_cnt;
  int          check_count;
  logic [31:0] rd;
  logic [2:0]  lf_cnt;
  int          cyc;
  // clock table: power/tap setting, select code, source period in cycles
  logic [2:0]  tcfg [9] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h4};
  logic [2:0]  tck  [9] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h0, 3'h0};
  int          tper [9] = '{2048, 128, 32, 8, 16, 2, 1, 128, 128};

  utc_upper_timer dut (
    .mclk_in(mclk_in), .rst_in(rst_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in),
    .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
    .wb_ack_out(wb_ack_out), .wb_dat_out(wb_dat_out),
    .low_freq_clk_in(low_freq_clk_in), .counter_pin_in(counter_pin_in),
    .cascade_ovf_in(cascade_ovf_in), .lower_match_in(lower_match_in),
    .timer_ff_out(timer_ff_out), .upper_match_irq_out(upper_match_irq_out),
    .irq_out(irq_out)
  );

  // ----------------------------------------------------------------
  // clocks
  // ----------------------------------------------------------------
  // 25 MHz system clock
  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end

  // low-frequency source, one rising edge every 16 system cycles
  always @(posedge mclk_in) begin
    lf_cnt <= lf_cnt + 3'h1;
    if (lf_cnt == 3'h7) low_freq_clk_in <= ~low_freq_clk_in;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one classic cycle; held until ack is sampled high, bounded wait
  task automatic wb(input logic we, input logic [5:0] idx, input logic [7:0] wd,
                    output logic [31:0] rdat);
    int t;
    t = 0;
    @(posedge mclk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in  <= we;
    wb_adr_in <= {idx, 2'b00};
    wb_dat_in <= {24'h000000, wd};
    @(posedge mclk_in);
    while (wb_ack_out !== 1'b1 && t < 20) begin
      @(posedge mclk_in);
      t++;
    end
    rdat = wb_dat_out;
    if (t >= 20) begin
      error_cnt++;
      $display("unexpected at %0t: no bus ack", $time);
    end
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    wb_we_in  <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] dummy;
    wb(1'b1, idx, d, dummy);
  endtask

  task automatic rc(input logic [5:0] idx, input logic [7:0] exp, input string what);
    logic [31:0] r;
    wb(1'b0, idx, 8'h00, r);
    chk(r, {24'h000000, exp}, what);
  endtask

  // waits for a match pulse, returns the cycles waited
  task automatic wait_match(output int c);
    c = 0;
    @(posedge mclk_in);
    while (upper_match_irq_out !== 1'b1 && c < 600) begin
      @(posedge mclk_in);
      c++;
    end
  endtask

  function automatic logic [7:0] ctl(input logic ff, input logic [2:0] ck,
                                     input logic run, input logic [2:0] m);
    return {ff, ck, run, m};
  endfunction

  task automatic results;
    if (error_cnt == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // watchdog sized well above the roughly 31k cycles of the sequence
  initial begin
    repeat (90000) @(posedge mclk_in);
    error_cnt++;
    $display("unexpected at %0t: watchdog expired", $time);
    results();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    error_cnt = 0;
    check_count = 0;
    rst_in = 1'b1;
    wb_cyc_in = 1'b0;
    wb_stb_in = 1'b0;
    wb_we_in = 1'b0;
    wb_adr_in = 8'h00;
    wb_sel_in = 4'hF;
    wb_dat_in = 32'h0;
    low_freq_clk_in = 1'b0;
    counter_pin_in = 1'b1;
    cascade_ovf_in = 1'b0;
    lower_match_in = 1'b0;
    lf_cnt = 3'h0;
    repeat (6) @(posedge mclk_in);
    rst_in <= 1'b0;
    // reset values and an unmapped place
    rc(IDX_CTRL, 8'h00, "ctrl reset");
    rc(IDX_PW, 8'hFF, "pw reset");
    rc(IDX_PER, 8'hFF, "per reset");
    rc(IDX_IST, 8'h00, "status reset");
    rc(IDX_IEN, 8'h00, "enable reset");
    wr(6'h00, 8'h5A);
    rc(6'h00, 8'h00, "unmapped");
    // every mode code is stored while stopped
    for (int m = 0; m < 8; m++) begin
      wr(IDX_CTRL, ctl(1'b0, 3'h2, 1'b0, m[2:0]));
      rc(IDX_CTRL, ctl(1'b0, 3'h2, 1'b0, m[2:0]), "mode code");
    end
    wr(IDX_CTRL, 8'h80);
    repeat (2) @(posedge mclk_in);
    chk(timer_ff_out, 1'b1, "ff load");
    wr(IDX_CTRL, 8'h00);
    wr(IDX_PW, 8'h21);
    rc(IDX_PW, 8'h21, "pw rw");
    // writes while running in timer mode are not taken, apart from the run bit
    wr(IDX_CTRL, 8'h38);
    wr(IDX_PER, 8'h10);
    rc(IDX_PER, 8'hFF, "per while running");
    wr(IDX_PW, 8'h33);
    rc(IDX_PW, 8'h21, "pw while running");
    wr(IDX_CTRL, 8'hB9);
    rc(IDX_CTRL, 8'h38, "fields while running");
    wr(IDX_CTRL, 8'hB1);
    rc(IDX_CTRL, 8'h30, "stop keeps fields");
    rc(IDX_CNT, 8'h00, "count after stop");
    wr(IDX_CTRL, 8'h6A);
    rc(IDX_CTRL, 8'h6A, "start programs fields");
    wr(IDX_PW, 8'h40);
    rc(IDX_PW, 8'h40, "pw in pwm");
    wr(IDX_CTRL, 8'h62);
    // match period, sticky status, level interrupt, clear
    wr(IDX_PER, 8'h05);
    wr(IDX_IEN, 8'h01);
    wr(IDX_CTRL, 8'h38);
    wait_match(cyc);
    wait_match(cyc);
    chk(cyc + 1, 40, "match spacing");
    wr(IDX_CTRL, 8'h30);
    chk(irq_out, 1'b1, "irq level");
    rc(IDX_IST, 8'h01, "status match");
    wr(IDX_ICLR, 8'h01);
    repeat (2) @(posedge mclk_in);
    chk(irq_out, 1'b0, "irq cleared");
    rc(IDX_IST, 8'h00, "status cleared");
    // masked event still sets status
    wr(IDX_IEN, 8'h00);
    wr(IDX_CTRL, 8'h38);
    wait_match(cyc);
    wr(IDX_CTRL, 8'h30);
    chk(irq_out, 1'b0, "irq masked");
    rc(IDX_IST, 8'h01, "status masked");
    wr(IDX_IEN, 8'h01);
    repeat (2) @(posedge mclk_in);
    chk(irq_out, 1'b1, "irq unmasked");
    // divider output toggles on every match
    wr(IDX_CTRL, 8'h39);
    wait_match(cyc);
    chk(timer_ff_out, 1'b1, "pdo first toggle");
    wait_match(cyc);
    chk(timer_ff_out, 1'b0, "pdo second toggle");
    wr(IDX_CTRL, 8'h31);
    wr(IDX_ICLR, 8'h03);
    wr(IDX_PER, 8'hFF);
    // event counting on falling pin edges
    wr(IDX_CTRL, 8'h78);
    for (int i = 0; i < 7; i++) begin
      counter_pin_in <= 1'b0;
      repeat (4) @(posedge mclk_in);
      counter_pin_in <= 1'b1;
      repeat (4) @(posedge mclk_in);
    end
    repeat (4) @(posedge mclk_in);
    rc(IDX_CNT, 8'h07, "event count");
    wr(IDX_CTRL, 8'h70);
    // 16-bit mode counts cascade pulses, not the fast internal clock
    wr(IDX_PER, 8'h03);
    wr(IDX_CTRL, 8'h6C);
    for (int i = 0; i < 3; i++) begin
      cascade_ovf_in <= 1'b1;
      @(posedge mclk_in);
      cascade_ovf_in <= 1'b0;
      repeat (2) @(posedge mclk_in);
    end
    rc(IDX_CNT, 8'h03, "cascade count");
    // upper half equal: match only once the lower half agrees
    lower_match_in <= 1'b1;
    @(posedge mclk_in);
    lower_match_in <= 1'b0;
    rc(IDX_CNT, 8'h00, "16-bit match clears");
    rc(IDX_IST, 8'h01, "16-bit match status");
    wr(IDX_CTRL, 8'h64);
    wr(IDX_ICLR, 8'h03);
    // slow power mode refuses the fast taps
    wr(IDX_CFG, 8'h04);
    wr(IDX_CTRL, 8'h1A);
    repeat (4) @(posedge mclk_in);
    rc(IDX_IST, 8'h02, "slow illegal clock");
    wr(IDX_CTRL, 8'h12);
    wr(IDX_ICLR, 8'h03);
    // source rate of every select code except the pin, free-running pwm mode
    for (int i = 0; i < 9; i++) begin
      wr(IDX_CFG, {5'h00, tcfg[i]});
      wr(IDX_CTRL, ctl(1'b0, tck[i], 1'b1, UTC_M_PWM8));
      repeat (12 * tper[i]) @(posedge mclk_in);
      wb(1'b0, IDX_CNT, 8'h00, rd);
      wr(IDX_CTRL, ctl(1'b0, tck[i], 1'b0, UTC_M_PWM8));
      check_count++;
      if ((rd >= 32'd11 && rd <= 32'd16) !== 1'b1) begin
        error_cnt++;
        $display("unexpected at %0t: rate entry %0d count %h", $time, i, rd);
      end
    end
    results();
  end

endmodule
`default_nettype wire
